/* File: design/sdc_pkg.sv */
// Purpose: shared constants and types of the synthesizer divider configuration logic
// Assumes: one 25 MHz system clock
// Notes: register map, field positions, reset values and command codes live here
package sdc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // widths
    localparam int FB_W = 10;
    localparam int NA_W = 3;
    localparam int PIN_W = 15;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] REG_LOW_ADDR = 8'h00;
    localparam logic [7:0] REG_HIGH_ADDR = 8'h01;
    localparam logic [7:0] REG_CMD_ADDR = 8'hF0;

    // high configuration byte field positions
    localparam int HI_FB_MSB = 7;
    localparam int HI_FB_LSB = 6;
    localparam int HI_NA_MSB = 5;
    localparam int HI_NA_LSB = 3;
    localparam int HI_NB_BIT = 2;
    localparam int HI_P_BIT = 1;
    localparam int HI_LOCK_BIT = 0;

    // command codes, low nibble one-hot
    localparam logic [3:0] CMD_STEP_UP = 4'h1;
    localparam logic [3:0] CMD_STEP_DOWN = 4'h2;
    localparam logic [3:0] CMD_LOAD = 4'h4;
    localparam logic [3:0] CMD_CAPTURE = 4'h8;

    ////////////////////////////////////////////////////////////////////////////////
    // values after reset, equal to the open-pin defaults
    localparam logic [9:0] FB_RESET = 10'h1F4;
    localparam logic [2:0] NA_RESET = 3'h3;
    localparam logic NB_RESET = 1'b0;
    localparam logic P_RESET = 1'b1;

    // division ratios
    localparam logic [2:0] PRE_RATIO_P0 = 3'h2;
    localparam logic [2:0] PRE_RATIO_P1 = 3'h4;
    localparam logic [2:0] NA_CODE_MAX = 3'h5;

    ////////////////////////////////////////////////////////////////////////////////
    // serial target
    localparam logic [4:0] I2C_ADDR_PREFIX = 5'h16;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] TX_LAST_BIT = 4'h7;

    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_MGO} sdc_i2c_state_t;
    typedef enum logic [1:0] {KIND_ADDR, KIND_REG, KIND_DATA} sdc_byte_kind_t;

endpackage

/* File: design/sdc_ratio_decode.sv */
// Purpose: turn the active divider settings into division ratios
// Assumes: settings come from flip-flops on the same clock
// Notes: undefined output-A codes give ratio zero
module sdc_ratio_decode import sdc_pkg::*; (
    // settings
    input wire logic p_sel,
    input wire logic [NA_W-1:0] na_code,
    input wire logic nb_sel,
    // ratios
    output logic [2:0] pre_ratio,
    output logic [6:0] a_ratio,
    output logic [7:0] b_ratio
);

    ////////////////////////////////////////////////////////////////////////////////
    // pre-divider, output-A and output-B ratio decode
    always_comb begin
        pre_ratio = p_sel ? PRE_RATIO_P1 : PRE_RATIO_P0;
        a_ratio = 7'h00;
        if (na_code <= NA_CODE_MAX) begin
            a_ratio = 7'(7'h02 << na_code);
        end
        b_ratio = nb_sel ? {a_ratio, 1'b0} : {1'b0, a_ratio};
    end

endmodule

/* File: design/sdc_sync.sv */
// Purpose: two-stage synchroniser for a bundle of independent levels
// Assumes: each bit is an unrelated level, no word coherence
// Notes: the first stage is read only by the second
module sdc_sync import sdc_pkg::*; #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_r;

    ////////////////////////////////////////////////////////////////////////////////
    // two flip-flops per bit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= RST_VAL; // idle levels, so no false edge or mode after reset
            q <= RST_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end

endmodule

/* File: design/sdc_top.sv */
// Purpose: divider configuration logic of a clock synthesizer, pins plus serial target
// Assumes: pins, serial lines and lock arrive asynchronously and are synchronised here
// Notes: open-pin defaults are pad pulls; the core reset values equal them
// How it works
// - pre-divider select picks divide by two or four
// - output-A codes 000..101 give 2 to 64
// - halve select makes output B half of A
// - parallel mode applies pin changes without a strobe
// - parallel mode ignores writes, still acks, serves reads
// - master reset release captures the pin configuration
// - serial mode ignores pins except at master reset release, opens register access
// - open pins default to 500, 011, 0, 1
// - pins are write only, readback via serial
// - device acts only as a serial target
// - map: low 0x00, high 0x01, command 0xF0
// - high byte packs fb msbs, code, halve, pre, lock
// - lock bit mirrors pll lock, writes ignored
// - register writes need load to reach dividers
// - capture copies active dividers into registers
// - step commands change feedback divider only
// - no range check on steps or loads
// - command low nibble one-hot decode
// - write is register address then data, repeated
// - read returns low then high, no address phase
// - target address is prefix plus two straps
module sdc_top import sdc_pkg::*; (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // parallel configuration pins
    input wire logic master_reset_n,
    input wire logic pin_config_select_n,
    input wire logic [FB_W-1:0] pin_fb_divider,
    input wire logic [NA_W-1:0] pin_output_a_divider_code,
    input wire logic pin_qb_halve_select,
    input wire logic pin_pre_div_select,
    input wire logic [1:0] addr_strap,
    // serial lines
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // pll side
    input wire logic pll_lock,
    output logic [FB_W-1:0] fb_divider,
    output logic [NA_W-1:0] output_a_divider_code,
    output logic qb_halve_select,
    output logic pre_div_select,
    output logic [2:0] pre_div_ratio,
    output logic [6:0] out_a_ratio,
    output logic [7:0] out_b_ratio
);

    ////////////////////////////////////////////////////////////////////////////////
    // reset release and input synchronisation
    logic rst_meta_r;
    logic rst_sync_n;
    logic [PIN_W-1:0] pins_s;
    logic sel_n_s, mr_s, scl_s, sda_s, lock_s;
    logic [1:0] strap_s;
    logic [FB_W-1:0] pin_fb_s;
    logic [NA_W-1:0] pin_na_s;
    logic pin_nb_s, pin_p_s;

    // reset asserts at once and leaves after two edges
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_n <= rst_meta_r;
        end
    end

    // reset levels: default pins, serial mode, mr low, lines idle high, no lock
    sdc_sync #(
        .W(PIN_W + 7),
        .RST_VAL({FB_RESET, NA_RESET, NB_RESET, P_RESET, 5'b10110, 2'b00})
    ) u_sync (
        .clk(sys_clk),
        .rst_n(rst_sync_n),
        .d({pin_fb_divider, pin_output_a_divider_code, pin_qb_halve_select, pin_pre_div_select,
            pin_config_select_n, master_reset_n, scl_in, sda_in, pll_lock, addr_strap}),
        .q({pins_s, sel_n_s, mr_s, scl_s, sda_s, lock_s, strap_s})
    );

    // split the synchronised pin word
    assign {pin_fb_s, pin_na_s, pin_nb_s, pin_p_s} = pins_s;

    ////////////////////////////////////////////////////////////////////////////////
    // serial line edge detection
    logic scl_d_r, sda_d_r, mr_d_r;
    logic scl_rise, scl_fall, bus_start, bus_stop, mr_rise, par_mode;

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            mr_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
            mr_d_r <= mr_s;
        end
    end

    // start and stop are data edges while the clock is high
    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign bus_stop = scl_s & scl_d_r & ~sda_d_r & sda_s;
    assign mr_rise = mr_s & ~mr_d_r;
    assign par_mode = ~sel_n_s;

    ////////////////////////////////////////////////////////////////////////////////
    // serial target state machine
    sdc_i2c_state_t st_r, st_nxt;
    sdc_byte_kind_t kind_r, kind_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic rw_r, rw_nxt;
    logic tx_high_r, tx_high_nxt;
    logic oe_n_r, oe_n_nxt;
    logic wr_stb_r, wr_stb_nxt;
    logic [7:0] wr_addr_r, wr_addr_nxt;
    logic [7:0] wr_data_r, wr_data_nxt;
    logic [7:0] low_r, high_r;
    logic [7:0] rd_low, rd_high;

    // read bytes; the lock bit is live, never stored
    assign rd_low = low_r;
    assign rd_high = {high_r[7:1], lock_s};

    always_comb begin
        st_nxt = st_r;
        kind_nxt = kind_r;
        cnt_nxt = cnt_r;
        sh_nxt = sh_r;
        ptr_nxt = ptr_r;
        rw_nxt = rw_r;
        tx_high_nxt = tx_high_r;
        oe_n_nxt = oe_n_r;
        wr_stb_nxt = 1'b0;
        wr_addr_nxt = wr_addr_r;
        wr_data_nxt = wr_data_r;
        if (bus_stop) begin
            st_nxt = ST_IDLE;
            oe_n_nxt = 1'b1;
        end else if (bus_start) begin
            st_nxt = ST_RX;
            kind_nxt = KIND_ADDR;
            cnt_nxt = 4'h0;
            oe_n_nxt = 1'b1;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    oe_n_nxt = 1'b1;
                end
                ST_RX: begin
                    if (scl_rise && cnt_r != BITS_PER_BYTE) begin
                        sh_nxt = {sh_r[6:0], sda_s};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
                        st_nxt = ST_ACK;
                        oe_n_nxt = 1'b0;
                        case (kind_r)
                            KIND_ADDR: begin
                                rw_nxt = sh_r[0];
                                if (sh_r[7:1] != {I2C_ADDR_PREFIX, strap_s}) begin
                                    st_nxt = ST_IDLE;
                                    oe_n_nxt = 1'b1;
                                end
                            end
                            KIND_REG: begin
                                ptr_nxt = sh_r;
                            end
                            default: begin
                                wr_stb_nxt = 1'b1;
                                wr_addr_nxt = ptr_r;
                                wr_data_nxt = sh_r;
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        cnt_nxt = 4'h0;
                        oe_n_nxt = 1'b1;
                        if (kind_r == KIND_ADDR && rw_r) begin
                            sh_nxt = rd_low;
                            oe_n_nxt = rd_low[7];
                            tx_high_nxt = 1'b1;
                            st_nxt = ST_TX;
                        end else begin
                            kind_nxt = (kind_r == KIND_REG) ? KIND_DATA : KIND_REG;
                            st_nxt = ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (cnt_r == TX_LAST_BIT) begin
                            oe_n_nxt = 1'b1;
                            st_nxt = ST_MACK;
                        end else begin
                            sh_nxt = {sh_r[6:0], 1'b0};
                            cnt_nxt = cnt_r + 4'h1;
                            oe_n_nxt = sh_r[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        st_nxt = sda_s ? ST_IDLE : ST_MGO;
                    end
                end
                ST_MGO: begin
                    if (scl_fall) begin
                        sh_nxt = tx_high_r ? rd_high : rd_low;
                        oe_n_nxt = tx_high_r ? rd_high[7] : rd_low[7];
                        tx_high_nxt = ~tx_high_r;
                        cnt_nxt = 4'h0;
                        st_nxt = ST_TX;
                    end
                end
                default: begin
                    st_nxt = ST_IDLE;
                    oe_n_nxt = 1'b1;
                end
            endcase
        end
    end

    // register the serial target state
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            st_r <= ST_IDLE;
            kind_r <= KIND_ADDR;
            cnt_r <= 4'h0;
            sh_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            tx_high_r <= 1'b0;
            oe_n_r <= 1'b1;
            wr_stb_r <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_data_r <= 8'h00;
        end else begin
            st_r <= st_nxt;
            kind_r <= kind_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            ptr_r <= ptr_nxt;
            rw_r <= rw_nxt;
            tx_high_r <= tx_high_nxt;
            oe_n_r <= oe_n_nxt;
            wr_stb_r <= wr_stb_nxt;
            wr_addr_r <= wr_addr_nxt;
            wr_data_r <= wr_data_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // configuration registers and active dividers
    logic [FB_W-1:0] act_fb_r, act_fb_nxt;
    logic [NA_W-1:0] act_na_r, act_na_nxt;
    logic act_nb_r, act_nb_nxt, act_p_r, act_p_nxt;
    logic [7:0] low_nxt, high_nxt;

    always_comb begin
        act_fb_nxt = act_fb_r;
        act_na_nxt = act_na_r;
        act_nb_nxt = act_nb_r;
        act_p_nxt = act_p_r;
        low_nxt = low_r;
        high_nxt = high_r;
        if (mr_rise || par_mode) begin
            // pins drive dividers and registers mirror them
            act_fb_nxt = pin_fb_s;
            act_na_nxt = pin_na_s;
            act_nb_nxt = pin_nb_s;
            act_p_nxt = pin_p_s;
            low_nxt = pin_fb_s[7:0];
            high_nxt = {pin_fb_s[9:8], pin_na_s, pin_nb_s, pin_p_s, 1'b0};
        end else if (wr_stb_r) begin
            // serial mode only; pins have no effect here
            case (wr_addr_r)
                REG_LOW_ADDR: begin
                    low_nxt = wr_data_r;
                end
                REG_HIGH_ADDR: begin
                    high_nxt = {wr_data_r[7:1], 1'b0};
                end
                REG_CMD_ADDR: begin
                    case (wr_data_r[3:0])
                        CMD_STEP_UP: begin
                            act_fb_nxt = act_fb_r + 10'h001;
                        end
                        CMD_STEP_DOWN: begin
                            act_fb_nxt = act_fb_r - 10'h001;
                        end
                        CMD_LOAD: begin
                            act_fb_nxt = {high_r[HI_FB_MSB:HI_FB_LSB], low_r};
                            act_na_nxt = high_r[HI_NA_MSB:HI_NA_LSB];
                            act_nb_nxt = high_r[HI_NB_BIT];
                            act_p_nxt = high_r[HI_P_BIT];
                        end
                        CMD_CAPTURE: begin
                            low_nxt = act_fb_r[7:0];
                            high_nxt = {act_fb_r[9:8], act_na_r, act_nb_r, act_p_r, 1'b0};
                        end
                        default: begin
                            act_fb_nxt = act_fb_r;
                        end
                    endcase
                end
                default: begin
                    low_nxt = low_r;
                end
            endcase
        end
    end

    // register configuration state; reset values equal the open-pin defaults
    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            act_fb_r <= FB_RESET;
            act_na_r <= NA_RESET;
            act_nb_r <= NB_RESET;
            act_p_r <= P_RESET;
            low_r <= FB_RESET[7:0];
            high_r <= {FB_RESET[9:8], NA_RESET, NB_RESET, P_RESET, 1'b0};
        end else begin
            act_fb_r <= act_fb_nxt;
            act_na_r <= act_na_nxt;
            act_nb_r <= act_nb_nxt;
            act_p_r <= act_p_nxt;
            low_r <= low_nxt;
            high_r <= high_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // ratio decode and registered outputs
    logic [2:0] pre_ratio_c;
    logic [6:0] a_ratio_c;
    logic [7:0] b_ratio_c;

    sdc_ratio_decode u_ratio (
        .p_sel(act_p_r),
        .na_code(act_na_r),
        .nb_sel(act_nb_r),
        .pre_ratio(pre_ratio_c),
        .a_ratio(a_ratio_c),
        .b_ratio(b_ratio_c)
    );

    always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            // ratios of the reset settings, so outputs agree from the first edge
            pre_div_ratio <= PRE_RATIO_P1;
            out_a_ratio <= 7'(7'h02 << NA_RESET);
            out_b_ratio <= 8'(7'h02 << NA_RESET);
            sda_out <= 1'b0;
        end else begin
            pre_div_ratio <= pre_ratio_c;
            out_a_ratio <= a_ratio_c;
            out_b_ratio <= b_ratio_c;
            sda_out <= 1'b0;
        end
    end

    // divider settings and the data enable come straight from their flops
    assign fb_divider = act_fb_r;
    assign output_a_divider_code = act_na_r;
    assign qb_halve_select = act_nb_r;
    assign pre_div_select = act_p_r;
    assign sda_oe_n = oe_n_r;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    AST_PRE_RATIO: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        ##1 pre_div_ratio == ($past(act_p_r) ? 3'h4 : 3'h2)) else $error("pre ratio wrong");
    AST_A_RATIO: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        (act_na_r == 3'h2) |=> out_a_ratio == 7'h08) else $error("code 010 not eight");
    AST_B_RATIO: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        act_nb_r && $stable(act_nb_r) && $stable(act_na_r) && act_na_r <= 3'h5 |=>
        out_b_ratio == {out_a_ratio, 1'b0}) else $error("b not half of a");
    AST_PIN_FOLLOW: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        par_mode |=> act_fb_r == $past(pin_fb_s) && act_na_r == $past(pin_na_s)) else $error("pins not applied");
    AST_PAR_NO_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        par_mode && wr_stb_r |=> low_r == $past(pin_fb_s[7:0])) else $error("write in parallel mode");
    AST_MR_CAPTURE: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        mr_rise |=> act_fb_r == $past(pin_fb_s) && act_p_r == $past(pin_p_s)) else $error("reset capture missed");
    AST_SERIAL_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        !par_mode && !mr_rise && !(wr_stb_r && wr_addr_r == REG_CMD_ADDR) |=> $stable(act_fb_r)) else
        $error("divider moved in serial mode");
    AST_HIGH_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        !par_mode && !mr_rise && wr_stb_r && wr_addr_r == REG_HIGH_ADDR |=>
        high_r == {$past(wr_data_r[7:1]), 1'b0} && $stable(act_na_r)) else $error("high write wrong");
    AST_LOAD: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        !par_mode && !mr_rise && wr_stb_r && wr_addr_r == REG_CMD_ADDR && wr_data_r[3:0] == CMD_LOAD |=>
        act_fb_r == $past({high_r[7:6], low_r})) else $error("load wrong");
    AST_CAPTURE: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        !par_mode && !mr_rise && wr_stb_r && wr_addr_r == REG_CMD_ADDR && wr_data_r[3:0] == CMD_CAPTURE |=>
        low_r == $past(act_fb_r[7:0])) else $error("capture wrong");
    AST_STEP_UP: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        !par_mode && !mr_rise && wr_stb_r && wr_addr_r == REG_CMD_ADDR && wr_data_r[3:0] == CMD_STEP_UP |=>
        act_fb_r == 10'($past(act_fb_r) + 10'h001) && $stable(low_r)) else $error("step up wrong");
    AST_ADDR_ACK: assert property (@(posedge sys_clk) disable iff (!rst_sync_n)
        st_r == ST_RX && kind_r == KIND_ADDR && scl_fall && cnt_r == 4'h8 && !bus_start && !bus_stop &&
        sh_r[7:1] == {5'h16, strap_s} |=> !sda_oe_n) else $error("own address not acked");

endmodule

/* File: test/sdc_i2c_host.sv */
// Purpose: serial bus controller model facing the divider configuration target
// Assumes: data wire is pulled up and both parties only pull it low
// Notes: all changes on falling clock edges, 8-clock bus phases
module sdc_i2c_host (
    // clock
    input wire logic clk,
    // bus lines
    output logic scl,
    output logic sda_drv,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask

    // one bit period; a 1 releases the line, s is the level seen at high clock
    task automatic bit_io(input logic b, output logic s);
        wt(2);
        sda_drv = b;
        wt(6);
        scl = 1'b1;
        wt(4);
        s = sda;
        wt(4);
        scl = 1'b0;
    endtask

    // eight bits msb first, then the acknowledge slot
    task automatic byte_io(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(mack, s);
        ack = !s;
    endtask

    // start (data falls) or stop (data rises) while the clock is high
    task automatic frame(input logic st);
        wt(2);
        sda_drv = st;
        wt(6);
        scl = 1'b1;
        wt(8);
        sda_drv = !st;
        wt(8);
        if (st) scl = 1'b0;
    endtask

    // write: target address, then one register address and one data byte
    task automatic wr(input logic [6:0] a, input logic [7:0] r, d, output logic ok);
        logic [7:0] q;
        logic k0, k1, k2;
        frame(1'b1);
        byte_io({a, 1'b0}, 1'b1, q, k0);
        byte_io(r, 1'b1, q, k1);
        byte_io(d, 1'b1, q, k2);
        frame(1'b0);
        ok = k0 & k1 & k2;
    endtask

    // read: address, low byte with ack, high byte with nack
    task automatic rd(input logic [6:0] a, output logic [7:0] lo, hi, output logic ok);
        logic [7:0] q;
        logic k;
        frame(1'b1);
        byte_io({a, 1'b1}, 1'b1, q, ok);
        if (ok) byte_io(8'hFF, 1'b0, lo, k);
        if (ok) byte_io(8'hFF, 1'b1, hi, k);
        frame(1'b0);
    endtask
endmodule

/* File: test/test_synth_divider_config_logic.sv */
// Purpose: self-checking bench of the divider configuration logic
// Assumes: strap pins fixed at 2'b10
// Notes: expected ratios derived from the settings, not read back
module test_synth_divider_config_logic import sdc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk, rst_n, master_reset_n, sel_n, pin_nb, pin_p, pll_lock, ok;
    logic [9:0] pin_fb;
    logic [2:0] pin_na;
    logic [7:0] lo, hi;
    wire scl, sda_drv, sda_out, sda_oe_n, nb, p;
    wire [9:0] fb;
    wire [2:0] na, pr;
    wire [6:0] ar;
    wire [7:0] br;
    wire sda = sda_drv & (sda_oe_n | sda_out);
    int err_count = 0;
    int samples_checked = 0;
    localparam logic [6:0] ADR = {I2C_ADDR_PREFIX, 2'b10};

    sdc_top u_sdc_top (.sys_clk(sys_clk), .rst_n(rst_n), .master_reset_n(master_reset_n),
        .pin_config_select_n(sel_n), .pin_fb_divider(pin_fb), .pin_output_a_divider_code(pin_na),
        .pin_qb_halve_select(pin_nb), .pin_pre_div_select(pin_p), .addr_strap(2'b10), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .pll_lock(pll_lock), .fb_divider(fb),
        .output_a_divider_code(na), .qb_halve_select(nb), .pre_div_select(p), .pre_div_ratio(pr),
        .out_a_ratio(ar), .out_b_ratio(br));
    sdc_i2c_host u_sdc_i2c_host (.clk(sys_clk), .scl(scl), .sda_drv(sda_drv), .sda(sda));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [9:0] e, g);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // active settings and the ratios they imply
    task automatic cfg(input logic [9:0] f, input logic [2:0] c, input logic b, q);
        logic [9:0] a;
        a = (c < 3'h6) ? (10'h2 << c) : 10'h0;
        chk("fb", f, fb);
        chk("na", {7'h0, c}, {7'h0, na});
        chk("nb", {9'h0, b}, {9'h0, nb});
        chk("pre", {9'h0, q}, {9'h0, pr == 3'h4 && p});
        chk("pre_ratio", q ? 10'h4 : 10'h2, {7'h0, pr});
        chk("a_ratio", a, {3'h0, ar});
        chk("b_ratio", b ? a << 1 : a, {2'h0, br});
    endtask

    task automatic pins(input logic [9:0] f, input logic [2:0] c, input logic b, q);
        pin_fb = f;
        pin_na = c;
        pin_nb = b;
        pin_p = q;
        repeat (6) @(negedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] r, d);
        u_sdc_i2c_host.wr(ADR, r, d, ok);
        chk("ack", 10'h1, {9'h0, ok});
        repeat (4) @(negedge sys_clk);
    endtask

    task automatic rd(input logic [7:0] el, eh);
        u_sdc_i2c_host.rd(ADR, lo, hi, ok);
        chk("ack", 10'h1, {9'h0, ok});
        chk("low", {2'h0, el}, {2'h0, lo});
        chk("high", {2'h0, eh}, {2'h0, hi});
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // watchdog well beyond the expected run length
    initial begin
        repeat (60000) @(negedge sys_clk);
        err_count++;
        complete_run();
    end

    initial begin
        {rst_n, master_reset_n, sel_n, pll_lock} = 4'b0011;
        {pin_fb, pin_na, pin_nb, pin_p} = {10'h1F4, 3'h3, 2'b01};
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        master_reset_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        cfg(10'h1F4, 3'h3, 1'b0, 1'b1);
        master_reset_n = 1'b0;
        pins(10'h2AB, 3'h5, 1'b1, 1'b0);
        master_reset_n = 1'b1;
        repeat (8) @(negedge sys_clk);
        cfg(10'h2AB, 3'h5, 1'b1, 1'b0);
        rd(8'hAB, 8'hAD);
        $display("reset capture test done");
        sel_n = 1'b0;
        for (int i = 0; i < 8; i++) begin
            pins(10'(10'h100 + i), i[2:0], i[0], i[1]);
            cfg(10'(10'h100 + i), i[2:0], i[0], i[1]);
        end
        wr(REG_LOW_ADDR, 8'h5A);
        pll_lock = 1'b0;
        rd(8'h07, 8'h7E);
        $display("parallel mode test done");
        sel_n = 1'b1;
        pins(10'h0, 3'h0, 1'b0, 1'b0);
        cfg(10'h107, 3'h7, 1'b1, 1'b1);
        wr(REG_LOW_ADDR, 8'h00);
        wr(REG_HIGH_ADDR, 8'h13);
        cfg(10'h107, 3'h7, 1'b1, 1'b1);
        rd(8'h00, 8'h12);
        wr(REG_CMD_ADDR, 8'h04);
        cfg(10'h000, 3'h2, 1'b0, 1'b1);
        wr(REG_CMD_ADDR, 8'h02);
        cfg(10'h3FF, 3'h2, 1'b0, 1'b1);
        wr(REG_CMD_ADDR, 8'hF1);
        wr(REG_CMD_ADDR, 8'h01);
        cfg(10'h001, 3'h2, 1'b0, 1'b1);
        rd(8'h00, 8'h12);
        wr(REG_CMD_ADDR, 8'h03);
        cfg(10'h001, 3'h2, 1'b0, 1'b1);
        wr(REG_CMD_ADDR, 8'h08);
        rd(8'h01, 8'h12);
        u_sdc_i2c_host.rd({I2C_ADDR_PREFIX, 2'b01}, lo, hi, ok);
        chk("nack", 10'h0, {9'h0, ok});
        $display("serial mode test done");
        complete_run();
    end
endmodule
